// ---- design/i2c_control_register_set.sv ----
// Control and status register set of one I2C controller channel
//
// Summary of operation
// - Debug-run bit keeps operating clock running in debug mode; clear stops it.
// - Two-bit source field selects among four sources; unsupported codes are refused.
// - Divider gives 1, 2, 4 or 8 for sources 0 and 2; others undivided.
// - Clock, mode, baud and own-address registers change only while disabled.
// - Ten-bit mode compares all ten own-address bits, else the low seven.
// - General-call enable makes the slave answer general calls; clear ignores them.
// - Baud value resets to 0x7F; software never programs zero.
// - Master-select bit picks master mode when set, slave mode when clear.
// - NACK request reads 1 while pending or sending, clears when sent.
// - STOP request in master mode reads 1 until bus free time elapsed.
// - START request in master mode reads 1 until the START is generated.
// - Soft reset clears transfer control and flags, reads 1 while running.
// - Module enable supplies the operating clock; clear stops it.
// - Writing transmit data clears tx-empty; flag is read-only.
// - Reading receive data clears rx-full; flag is read-only.
// - Status bits 12 and 11 show data and clock line low.
// - Status bit 10 shows bus busy.
// - Status bit 9 shows transmitting versus receiving.
// - Eight flags set on their cause; write 1 clears bits 7 to 2.
// - Interrupt enable bits sit at the same positions as the flags.
// - Interrupt request stands while any set flag has its enable.
module i2c_control_register_set
    import i2c_regs_pkg::*;
#(
    parameter logic [3:0] SRC_SUPPORTED = 4'hF
) (
    // Clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_resetn,
    // Register port
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [DATA_W-1:0]   i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic      [DATA_W-1:0]   o_rdata,
    // Clock sources as enable ticks, debug state
    input  wire logic [3:0]          i_src_tick,
    input  wire logic                i_debug_mode,
    output logic                     o_op_clk_en,
    // Bus lines as seen at the pins
    input  wire logic                i_scl,
    input  wire logic                i_sda,
    // Events from the protocol engine
    input  wire logic                i_evt_byte_end,
    input  wire logic                i_evt_gen_call,
    input  wire logic                i_evt_nack,
    input  wire logic                i_evt_stop,
    input  wire logic                i_evt_start,
    input  wire logic                i_evt_error,
    input  wire logic                i_evt_rx_load,
    input  wire logic [7:0]          i_rx_byte,
    input  wire logic                i_evt_tx_empty,
    input  wire logic                i_nack_sent,
    input  wire logic                i_start_done,
    input  wire logic                i_stop_done,
    input  wire logic                i_transmitting,
    // Slave address check
    input  wire logic                i_addr_valid,
    input  wire logic                i_addr_is_gc,
    input  wire logic [OWN_SLAVE_ADDR_W-1:0]   i_addr_word,
    output logic                     o_addr_ack,
    // Settings and requests to the protocol engine
    output logic                     o_enable,
    output logic                     o_master,
    output logic [BAUD_W-1:0]        o_baud,
    output logic                     o_start_req,
    output logic                     o_stop_req,
    output logic                     o_nack_req,
    output logic                     o_soft_reset,
    output logic [7:0]               o_tx_data,
    output logic                     o_tx_empty,
    output logic                     o_irq
);

    // ****************************************
    // Register port decode
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
        return a == idx;
    endfunction

    logic                  dbg_run_r;
    logic [1:0]            div_sel_r;
    logic [1:0]            src_sel_r;
    logic                  ten_bit_r;
    logic                  gc_en_r;
    logic [BAUD_W-1:0]     baud_r;
    logic [OWN_SLAVE_ADDR_W-1:0]     own_addr_r;
    logic                  mst_r;
    logic                  nack_r;
    logic                  stop_r;
    logic                  start_r;
    logic                  enable_r;
    logic [7:0]            tx_data_r;
    logic [7:0]            rx_data_r;
    logic [FLAG_W-1:0]     flags_r;
    logic [FLAG_W-1:0]     irq_en_r;
    srst_state_type        state_r;
    logic [2:0]            srst_cnt_r;
    logic                  srst;

    wire cfg_open = ~enable_r;
    wire wr_clk   = i_wr & hit(i_addr, IDX_CLK) & cfg_open;
    wire wr_mod   = i_wr & hit(i_addr, IDX_MOD) & cfg_open;
    wire wr_baud  = i_wr & hit(i_addr, IDX_BAUD) & cfg_open;
    wire wr_own_slave_addr  = i_wr & hit(i_addr, IDX_OWN_SLAVE_ADDR) & cfg_open;
    wire wr_ctl   = i_wr & hit(i_addr, IDX_CTL);
    wire wr_txd   = i_wr & hit(i_addr, IDX_TXD);
    wire wr_intf  = i_wr & hit(i_addr, IDX_INTF);
    wire wr_inte  = i_wr & hit(i_addr, IDX_INTE);
    wire rd_rxd   = i_rd & hit(i_addr, IDX_RXD);

    wire [1:0] src_wr = i_wdata[CLK_SRC_LSB +: 2];
    wire       src_ok = SRC_SUPPORTED[src_wr];
    wire       mst_wr = i_wdata[CTL_MST_BIT];

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            dbg_run_r  <= 1'b0;
            div_sel_r  <= DIV_RST;
            src_sel_r  <= SRC_RST;
            ten_bit_r  <= 1'b0;
            gc_en_r    <= 1'b0;
            baud_r     <= BAUD_RST;
            own_addr_r <= '0;
            irq_en_r   <= '0;
            tx_data_r  <= '0;
        end else begin
            if (wr_clk) begin
                dbg_run_r <= i_wdata[CLK_DEBUG_CLOCK_RUN_BIT];
                div_sel_r <= i_wdata[CLK_DIV_LSB +: 2];
                if (src_ok) begin
                    src_sel_r <= src_wr;
                end
            end
            if (wr_mod) begin
                ten_bit_r <= i_wdata[MOD_TEN_BIT];
                gc_en_r   <= i_wdata[MOD_GC_BIT];
            end
            if (wr_baud) begin
                baud_r <= i_wdata[BAUD_W-1:0];
            end
            if (wr_own_slave_addr) begin
                own_addr_r <= i_wdata[OWN_SLAVE_ADDR_W-1:0];
            end
            if (wr_inte) begin
                irq_en_r <= i_wdata[FLAG_W-1:0];
            end
            if (wr_txd) begin
                tx_data_r <= i_wdata[7:0];
            end
        end
    end

    // ****************************************
    // Control register and requests
    // ****************************************
    // A hardware done pulse in the same cycle as a software request loses:
    // the new request stays pending so it is never silently dropped.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mst_r    <= 1'b0;
            enable_r <= 1'b0;
        end else if (wr_ctl) begin
            mst_r    <= mst_wr;
            enable_r <= i_wdata[CTL_EN_BIT];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn || srst) begin
            nack_r  <= 1'b0;
            stop_r  <= 1'b0;
            start_r <= 1'b0;
        end else begin
            if (wr_ctl && i_wdata[CTL_NACK_BIT]) begin
                nack_r <= 1'b1;
            end else if (i_nack_sent) begin
                nack_r <= 1'b0;
            end
            if (wr_ctl && i_wdata[CTL_STOP_BIT] && mst_wr) begin
                stop_r <= 1'b1;
            end else if (i_stop_done) begin
                stop_r <= 1'b0;
            end
            if (wr_ctl && i_wdata[CTL_START_BIT] && mst_wr) begin
                start_r <= 1'b1;
            end else if (i_start_done) begin
                start_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // Soft reset sequencer
    // ****************************************
    wire srst_go = wr_ctl & i_wdata[CTL_SRST_BIT];
    assign srst  = state_r[1];

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_r    <= ST_RUN;
            srst_cnt_r <= '0;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (srst_go) begin
                        state_r    <= ST_SRST;
                        srst_cnt_r <= SRST_LAST;
                    end
                end
                ST_SRST: begin
                    if (srst_cnt_r == '0) begin
                        state_r <= ST_RUN;
                    end else begin
                        srst_cnt_r <= srst_cnt_r - 3'd1;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Interrupt flags
    // ****************************************
    wire [FLAG_W-1:0] flag_set = {i_evt_byte_end,
                                  i_evt_gen_call & gc_en_r,
                                  i_evt_nack,
                                  i_evt_stop,
                                  i_evt_start,
                                  i_evt_error,
                                  i_evt_rx_load,
                                  i_evt_tx_empty};
    wire [FLAG_W-1:0] w1c      = wr_intf ? (i_wdata[FLAG_W-1:0] & FLAG_W1C_MASK) : '0;
    wire [FLAG_W-1:0] flag_clr = w1c | {6'h00, rd_rxd, wr_txd};

    genvar g;
    generate
        for (g = 0; g < FLAG_W; g++) begin : g_flag
            always_ff @(posedge i_mclk) begin
                if (!i_resetn || srst) begin
                    flags_r[g] <= 1'b0;
                end else if (flag_set[g]) begin
                    flags_r[g] <= 1'b1;
                end else if (flag_clr[g]) begin
                    flags_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_data_r <= '0;
        end else if (i_evt_rx_load) begin
            rx_data_r <= i_rx_byte;
        end
    end

    // ****************************************
    // Operating clock enable
    // ****************************************
    logic [2:0] div_cnt_r;

    function automatic logic [2:0] div_last(input logic [1:0] code);
        return 3'((4'h1 << code) - 4'h1);
    endfunction

    wire       clk_gate  = enable_r & (~i_debug_mode | dbg_run_r);
    wire       src_tick  = i_src_tick[src_sel_r];
    wire       undivided = src_sel_r[0];
    wire       div_done  = undivided | (div_cnt_r == div_last(div_sel_r));

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            div_cnt_r   <= '0;
            o_op_clk_en <= 1'b0;
        end else if (!clk_gate) begin
            div_cnt_r   <= '0;
            o_op_clk_en <= 1'b0;
        end else begin
            o_op_clk_en <= src_tick & div_done;
            if (src_tick) begin
                div_cnt_r <= div_done ? 3'd0 : div_cnt_r + 3'd1;
            end
        end
    end

    // ****************************************
    // Line sampling and bus busy
    // ****************************************
    // Three stages: the first absorbs metastability, stages two and three must
    // agree before a level counts, which also rejects one-sample glitches.
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic       scl_lvl_r;
    logic       sda_lvl_r;
    logic       busy_r;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
        end else begin
            scl_s_r <= {scl_s_r[1:0], i_scl};
            sda_s_r <= {sda_s_r[1:0], i_sda};
        end
    end

    wire scl_new   = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_lvl_r;
    wire sda_new   = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_lvl_r;
    wire start_det = scl_lvl_r & scl_new & sda_lvl_r & ~sda_new;
    wire stop_det  = scl_lvl_r & scl_new & ~sda_lvl_r & sda_new;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            scl_lvl_r <= 1'b1;
            sda_lvl_r <= 1'b1;
            busy_r    <= 1'b0;
        end else begin
            scl_lvl_r <= scl_new;
            sda_lvl_r <= sda_new;
            if (srst || stop_det) begin
                busy_r <= 1'b0;
            end else if (start_det) begin
                busy_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Slave address comparison
    // ****************************************
    wire addr_eq  = ten_bit_r ? (i_addr_word == own_addr_r)
                              : (i_addr_word[OADR7_W-1:0] == own_addr_r[OADR7_W-1:0]);
    wire addr_hit = i_addr_is_gc ? gc_en_r : addr_eq;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_addr_ack <= 1'b0;
        end else begin
            o_addr_ack <= i_addr_valid & addr_hit & ~mst_r;
        end
    end

    // ****************************************
    // Read data and interrupt request
    // ****************************************
    wire [DATA_W-1:0] w_clk  = {7'h00, dbg_run_r, 2'h0, div_sel_r, 2'h0, src_sel_r};
    wire [DATA_W-1:0] w_mod  = {13'h0000, ten_bit_r, gc_en_r, 1'b0};
    wire [DATA_W-1:0] w_baud = {9'h000, baud_r};
    wire [DATA_W-1:0] w_own_slave_addr = {6'h00, own_addr_r};
    wire [DATA_W-1:0] w_ctl  = {10'h000, mst_r, nack_r, stop_r, start_r, srst, enable_r};
    wire [DATA_W-1:0] w_txd  = {8'h00, tx_data_r};
    wire [DATA_W-1:0] w_rxd  = {8'h00, rx_data_r};
    wire [DATA_W-1:0] w_intf = {3'h0, ~sda_lvl_r, ~scl_lvl_r, busy_r,
                                i_transmitting, 1'b0, flags_r};
    wire [DATA_W-1:0] w_inte = {8'h00, irq_en_r};

    wire [DATA_W-1:0] rd_word =
        hit(i_addr, IDX_CLK)  ? w_clk  :
        hit(i_addr, IDX_MOD)  ? w_mod  :
        hit(i_addr, IDX_BAUD) ? w_baud :
        hit(i_addr, IDX_OWN_SLAVE_ADDR) ? w_own_slave_addr :
        hit(i_addr, IDX_CTL)  ? w_ctl  :
        hit(i_addr, IDX_TXD)  ? w_txd  :
        hit(i_addr, IDX_RXD)  ? w_rxd  :
        hit(i_addr, IDX_INTF) ? w_intf :
        hit(i_addr, IDX_INTE) ? w_inte : '0;

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rdata <= '0;
            o_irq   <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rd_word : '0;
            o_irq   <= |(flags_r & irq_en_r);
        end
    end

    // Settings and requests leave straight from their registers
    assign o_enable     = enable_r;
    assign o_master     = mst_r;
    assign o_baud       = baud_r;
    assign o_start_req  = start_r;
    assign o_stop_req   = stop_r;
    assign o_nack_req   = nack_r;
    assign o_soft_reset = state_r[1];
    assign o_tx_data    = tx_data_r;
    assign o_tx_empty   = flags_r[FLAG_TBE_BIT];

endmodule

// ---- design/i2c_regs_pkg.sv ----
// Register map, field layout and reset values of the I2C control register set
package i2c_regs_pkg;
    // ****************************************
    // Register word indices on the plain port
    // ****************************************
    localparam int               ADDR_W       = 4;
    localparam logic [ADDR_W-1:0] IDX_CLK      = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_MOD      = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_BAUD     = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_OWN_SLAVE_ADDR     = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_CTL      = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_TXD      = 4'h5;
    localparam logic [ADDR_W-1:0] IDX_RXD      = 4'h6;
    localparam logic [ADDR_W-1:0] IDX_INTF     = 4'h7;
    localparam logic [ADDR_W-1:0] IDX_INTE     = 4'h8;
    localparam int               DATA_W       = 16;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CLK_DEBUG_CLOCK_RUN_BIT = 8;
    localparam int CLK_DIV_LSB   = 4;
    localparam int CLK_SRC_LSB   = 0;
    localparam int MOD_TEN_BIT   = 2;
    localparam int MOD_GC_BIT    = 1;
    localparam int CTL_MST_BIT   = 5;
    localparam int CTL_NACK_BIT  = 4;
    localparam int CTL_STOP_BIT  = 3;
    localparam int CTL_START_BIT = 2;
    localparam int CTL_SRST_BIT  = 1;
    localparam int CTL_EN_BIT    = 0;
    localparam int FLAG_W        = 8;
    localparam int BAUD_W        = 7;
    localparam int OWN_SLAVE_ADDR_W        = 10;
    localparam int OADR7_W       = 7;

    // Flags 7..2 clear by writing 1; rx full and tx empty only by data access or soft reset
    localparam logic [FLAG_W-1:0] FLAG_W1C_MASK = 8'hFC;
    localparam int                FLAG_RBF_BIT  = 1;
    localparam int                FLAG_TBE_BIT  = 0;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [BAUD_W-1:0] BAUD_RST   = 7'h7F;
    localparam logic [1:0]        SRC_RST    = 2'h0;
    localparam logic [1:0]        DIV_RST    = 2'h0;
    localparam int                SRST_CYC   = 4;
    localparam logic [2:0]        SRST_LAST  = 3'(SRST_CYC - 1);

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_SRST = 2'b10
    } srst_state_type;
endpackage

// ---- testbench/i2c_bus_agent.sv ----
// Far-side bus agent: START, running clock, STOP on a pulled-up line pair
module i2c_bus_agent (
    input  wire logic i_frame,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // Lines rest at the pull-up level; clock only runs inside a frame
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        forever begin
            @(posedge i_frame);
            #100 o_sda = 1'b0;
            while (i_frame) begin
                #100 o_scl = ~o_scl;
            end
            #100 o_scl = 1'b1;
            #100 o_sda = 1'b1;
        end
    end
endmodule

// ---- testbench/i2c_regs_props.sv ----
// Concurrent checks on the ports of the I2C control register set
module i2c_regs_props
    import i2c_regs_pkg::*;
(
    input wire logic              i_mclk,
    input wire logic              i_resetn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              i_start_done,
    input wire logic              i_evt_tx_empty,
    input wire logic              i_evt_rx_load,
    input wire logic [7:0]        i_rx_byte,
    input wire logic              i_addr_valid,
    input wire logic              o_op_clk_en,
    input wire logic              o_addr_ack,
    input wire logic              o_enable,
    input wire logic              o_master,
    input wire logic [BAUD_W-1:0] o_baud,
    input wire logic              o_start_req,
    input wire logic              o_nack_req,
    input wire logic              o_soft_reset,
    input wire logic [7:0]        o_tx_data,
    input wire logic              o_tx_empty,
    input wire logic              o_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    wire ctl_wr = i_wr && i_addr == IDX_CTL;
    // ****************************************
    // Properties
    // ****************************************
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside its slot");
    baud_lock_a: assert property (o_enable && i_wr && i_addr == IDX_BAUD |=> $stable(o_baud))
        else $error("baud changed while enabled");
    start_slave_a: assert property (ctl_wr && !i_wdata[CTL_MST_BIT] && !o_start_req |=> !o_start_req)
        else $error("start request taken in slave mode");
    start_clear_a: assert property (o_start_req && i_start_done && !ctl_wr |=> !o_start_req)
        else $error("start request not cleared");
    nack_set_a: assert property (ctl_wr && i_wdata[CTL_NACK_BIT] && !i_wdata[CTL_SRST_BIT]
        && !o_soft_reset |=> o_nack_req)
        else $error("nack request not held");
    srst_len_a: assert property ($rose(o_soft_reset) |-> o_soft_reset [*4] ##1 !o_soft_reset)
        else $error("soft reset length wrong");
    txd_write_a: assert property (i_wr && i_addr == IDX_TXD && !i_evt_tx_empty
        |=> !o_tx_empty && o_tx_data == $past(i_wdata[7:0]))
        else $error("transmit write mishandled");
    tbe_set_a: assert property (i_evt_tx_empty && !o_soft_reset |=> o_tx_empty)
        else $error("tx empty flag not set");
    clk_off_a: assert property (!o_enable && !$past(o_enable) |-> !o_op_clk_en)
        else $error("clock runs while disabled");
    slave_ack_a: assert property (i_addr_valid && o_master |=> !o_addr_ack)
        else $error("address acknowledged in master mode");
    rx_read_a: assert property (i_evt_rx_load ##1 (i_rd && i_addr == IDX_RXD && !i_evt_rx_load)
        |=> o_rdata == {8'h00, $past(i_rx_byte, 2)})
        else $error("receive data wrong");
    cover property ($rose(o_soft_reset));
    cover property (o_addr_ack);
    cover property ($rose(o_irq));
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the I2C control register set
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import i2c_regs_pkg::*;
    logic              i_mclk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, frame = 0, dbg = 0;
    logic              xmit = 0, avalid = 0, agc = 0, scl, sda, op_en, ack, irq;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0, o_rdata;
    logic [3:0]        tick = '0;
    logic [7:0]        evt = '0, rxb = 8'hA5, tx_data;
    logic [2:0]        done = '0;
    logic [OWN_SLAVE_ADDR_W-1:0] aword = '0;
    logic [15:0]       cv[8] = '{16'h0000, 16'h0010, 16'h0020, 16'h0030, 16'h0031, 16'h0033,
                                 16'h0000, 16'h0100};
    int                ev[8] = '{16, 8, 4, 2, 16, 16, 0, 16};
    int                miscompares = 0, tests_run = 0, cnt = 0;

    i2c_bus_agent u_i2c_bus_agent (.i_frame(frame), .o_scl(scl), .o_sda(sda));
    i2c_control_register_set u_i2c_control_register_set (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_tick(tick), .i_debug_mode(dbg),
        .o_op_clk_en(op_en), .i_scl(scl), .i_sda(sda), .i_evt_byte_end(evt[7]),
        .i_evt_gen_call(evt[6]), .i_evt_nack(evt[5]), .i_evt_stop(evt[4]),
        .i_evt_start(evt[3]), .i_evt_error(evt[2]), .i_evt_rx_load(evt[1]),
        .i_rx_byte(rxb), .i_evt_tx_empty(evt[0]), .i_nack_sent(done[0]),
        .i_start_done(done[1]), .i_stop_done(done[2]), .i_transmitting(xmit),
        .i_addr_valid(avalid), .i_addr_is_gc(agc), .i_addr_word(aword), .o_addr_ack(ack),
        .o_enable(), .o_master(), .o_baud(), .o_start_req(), .o_stop_req(), .o_nack_req(),
        .o_soft_reset(), .o_tx_data(tx_data), .o_tx_empty(), .o_irq(irq));

    initial forever #12.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (op_en === 1'b1) cnt++;
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rdm(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata & m, e);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rdm(a, 16'hFFFF, e);
    endtask
    task automatic ev_pulse(input logic [7:0] e, input logic [2:0] d);
        @(posedge i_mclk);
        evt <= e;
        done <= d;
        @(posedge i_mclk);
        evt <= 8'h00;
        done <= 3'h0;
    endtask
    task automatic addr_chk(input logic [OWN_SLAVE_ADDR_W-1:0] w, input logic g, input logic e);
        @(posedge i_mclk);
        avalid <= 1'b1;
        aword <= w;
        agc <= g;
        @(posedge i_mclk);
        avalid <= 1'b0;
        #1 chk(16'(ack), 16'(e));
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(IDX_BAUD, 16'h007F);
        rd(IDX_INTF, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(IDX_CLK, 16'hFFFF);
        rd(IDX_CLK, 16'h0133);
        wr(IDX_MOD, 16'hFFFF);
        rd(IDX_MOD, 16'h0006);
        wr(IDX_OWN_SLAVE_ADDR, 16'hFFFF);
        rd(IDX_OWN_SLAVE_ADDR, 16'h03FF);
        wr(IDX_CTL, 16'h0001);
        wr(IDX_BAUD, 16'h0011);
        rd(IDX_BAUD, 16'h007F);
        for (int k = 0; k < 8; k++) begin
            wr(IDX_CTL, 16'h0000);
            wr(IDX_CLK, cv[k]);
            wr(IDX_CTL, 16'h0001);
            dbg <= (k > 5);
            #1 cnt = 0;
            repeat (16) begin
                @(posedge i_mclk);
                tick <= 4'(1 << cv[k][1:0]);
            end
            @(posedge i_mclk);
            tick <= 4'h0;
            repeat (3) @(posedge i_mclk);
            #1 chk(16'(cnt), 16'(ev[k]));
        end
        dbg <= 1'b0;
        wr(IDX_CTL, 16'h0000);
        wr(IDX_MOD, 16'h0002);
        wr(IDX_OWN_SLAVE_ADDR, 16'h0255);
        wr(IDX_CTL, 16'h0001);
        addr_chk(10'h0D5, 1'b0, 1'b1);
        addr_chk(10'h054, 1'b0, 1'b0);
        addr_chk(10'h000, 1'b1, 1'b1);
        wr(IDX_CTL, 16'h0000);
        wr(IDX_MOD, 16'h0004);
        wr(IDX_CTL, 16'h0003);
        addr_chk(10'h0D5, 1'b0, 1'b0);
        addr_chk(10'h255, 1'b0, 1'b1);
        addr_chk(10'h000, 1'b1, 1'b0);
        wr(IDX_CTL, 16'h0025);
        rd(IDX_CTL, 16'h0025);
        addr_chk(10'h255, 1'b0, 1'b0);
        ev_pulse(8'h00, 3'h2);
        rd(IDX_CTL, 16'h0021);
        wr(IDX_CTL, 16'h000D);
        rd(IDX_CTL, 16'h0001);
        wr(IDX_CTL, 16'h0029);
        ev_pulse(8'h00, 3'h4);
        rd(IDX_CTL, 16'h0021);
        wr(IDX_CTL, 16'h0011);
        rd(IDX_CTL, 16'h0011);
        ev_pulse(8'h00, 3'h1);
        rd(IDX_CTL, 16'h0001);
        ev_pulse(8'hFF, 3'h0);
        rd(IDX_INTF, 16'h00BF);
        chk(16'(irq), 16'h0000);
        wr(IDX_INTE, 16'hFFFF);
        rd(IDX_INTE, 16'h00FF);
        chk(16'(irq), 16'h0001);
        wr(IDX_INTF, 16'h00FF);
        rd(IDX_INTF, 16'h0003);
        fork
            ev_pulse(8'h02, 3'h0);
            @(posedge i_mclk) rd(IDX_RXD, 16'h00A5);
        join
        rd(IDX_INTF, 16'h0001);
        wr(IDX_TXD, 16'hFF5A);
        rd(IDX_INTF, 16'h0000);
        chk(16'(tx_data), 16'h005A);
        chk(16'(irq), 16'h0000);
        ev_pulse(8'h04, 3'h0);
        wr(IDX_CTL, 16'h0003);
        rd(IDX_CTL, 16'h0003);
        repeat (4) @(posedge i_mclk);
        rd(IDX_CTL, 16'h0001);
        rd(IDX_INTF, 16'h0000);
        xmit <= 1'b1;
        frame <= 1'b1;
        repeat (20) @(posedge i_mclk);
        rdm(IDX_INTF, 16'h1600, 16'h1600);
        frame <= 1'b0;
        repeat (30) @(posedge i_mclk);
        rd(IDX_INTF, 16'h0200);
        results();
    end
    initial begin
        #100us;
        miscompares++;
        results();
    end
endmodule

bind i2c_control_register_set i2c_regs_props u_i2c_regs_props (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_start_done(i_start_done),
    .i_evt_tx_empty(i_evt_tx_empty), .i_evt_rx_load(i_evt_rx_load), .i_rx_byte(i_rx_byte),
    .i_addr_valid(i_addr_valid), .o_op_clk_en(o_op_clk_en), .o_addr_ack(o_addr_ack),
    .o_enable(o_enable), .o_master(o_master), .o_baud(o_baud), .o_start_req(o_start_req),
    .o_nack_req(o_nack_req), .o_soft_reset(o_soft_reset), .o_tx_data(o_tx_data),
    .o_tx_empty(o_tx_empty), .o_irq(o_irq));
